// file: core/lmd_ctrl.sv
// led matrix control: pwm scan, fault detect, de-ghost gating, shutdown
// assumes register port is synchronous; duty memory at offsets 0x00..0x8F
// Contract
// - only pwm mode: each led modulated over 256 duty steps
// - duty code is a step index; 0000 0100 is fourth step
// - group select bit and row field choose eight leds for test
// - trigger 00 to 01 starts open test, 00 to 10 short test
// - results valid within two scan cycles; host waits that long
// - results not refreshed while trigger merely held set
// - one test per trigger; host clears then sets to retest
// - pull-down on each of nine rows, pull-up on sixteen columns
// - pull resistor connects only while its output is off
// - all registers kept through both shutdowns
// - soft shutdown bit 0 blanks matrix, registers stay accessible
// - shutdown pin low blanks matrix, registers stay accessible
// - shutdown pin high resumes driving the matrix
// - trigger decode: 00 off, 01 or 11 open, 10 short
// - row field codes 0001..1001 select rows one to nine
// - group 0: cols 16..14,7..3; group 1: cols 13..8,2..1
// - eight results of the group in a read-only register
`timescale 1ns/1ps
`include "lmd_cfg.svh"
module lmd_ctrl #(
  parameter int ROWS = `LMD_NUM_ROWS,
  parameter int COLS = `LMD_NUM_COLS,
  parameter logic [15:0] SLOT_CYCLES = `LMD_SLOT_CYCLES
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic shutdown_pin_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [COLS-1:0] col_open_sense_i,
  input wire logic [COLS-1:0] col_short_sense_i,
  output logic [ROWS-1:0] row_source_on_o,
  output logic [COLS-1:0] column_sink_on_o,
  output logic [ROWS-1:0] row_source_pull_en_o,
  output logic [COLS-1:0] column_sink_pull_en_o,
  output logic [7:0] global_current_level_o,
  output logic [7:0] pull_voltage_select_o
);
  // ==========================================================
  // reset release
  logic rst_s1_ff, rst_n;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n <= rst_s1_ff;
    end
  end

  // ==========================================================
  // helpers
  // maps row code 0001..1001 to row index, other codes give none
  function automatic logic [3:0] row_index(input logic [3:0] code);
    row_index = (code >= 4'h1 && code <= 4'h9) ? code - 4'h1 : 4'hF;
  endfunction
  // row that follows r in the scan order
  function automatic logic [3:0] next_row(input logic [3:0] r);
    next_row = (r == 4'(ROWS - 1)) ? 4'h0 : r + 4'h1;
  endfunction
  // column (0-based) tested by bit b of the result for a given group
  function automatic logic [3:0] group_col(input logic grp, input logic [2:0] b);
    logic [3:0] c;
    c = 4'h0;
    if (!grp) begin
      c = (b >= 3'h5) ? 4'(4'hF - (3'h7 - b)) : 4'(4'h6 - (3'h4 - b));
    end else begin
      c = (b >= 3'h2) ? 4'(4'hC - (3'h7 - b)) : 4'(4'h1 - (3'h1 - b));
    end
    group_col = c;
  endfunction

  // ==========================================================
  // register file
  logic [7:0] config_ff, nxt_config;
  logic [7:0] gcl_ff, nxt_gcl;
  logic [7:0] pull_ff, nxt_pull;
  logic [7:0] ften_ff, nxt_ften;
  logic [7:0] fres_ff, nxt_fres;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic rd_mem_ff, nxt_rd_mem;
  lmd_mem_if #(.AW(8)) mem_bus ();
  logic mem_we;
  assign mem_we = reg_wr_i && (int'(reg_addr_i) < ROWS * COLS);
  always_comb begin
    nxt_config = config_ff;
    nxt_gcl = gcl_ff;
    nxt_pull = pull_ff;
    nxt_ften = ften_ff;
    nxt_rd_mem = 1'b0;
    nxt_rvalid = reg_rd_i;
    nxt_rdata = rdata_ff;
    // registers keep contents in any shutdown state
    if (reg_wr_i) begin
      case (reg_addr_i)
        `LMD_OFS_CONFIG: nxt_config = reg_wdata_i;
        `LMD_OFS_GCL: nxt_gcl = reg_wdata_i;
        `LMD_OFS_PULL: nxt_pull = reg_wdata_i;
        `LMD_OFS_FTEN: nxt_ften = {1'b0, reg_wdata_i[6:0]};
        default: nxt_ften = ften_ff;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        `LMD_OFS_CONFIG: nxt_rdata = config_ff;
        `LMD_OFS_GCL: nxt_rdata = gcl_ff;
        `LMD_OFS_PULL: nxt_rdata = pull_ff;
        `LMD_OFS_FTEN: nxt_rdata = ften_ff;
        `LMD_OFS_FTRES: nxt_rdata = fres_ff;
        default: begin
          nxt_rdata = 8'h00;
          nxt_rd_mem = int'(reg_addr_i) < ROWS * COLS;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      config_ff <= `LMD_RST_CONFIG;
      gcl_ff <= `LMD_RST_GCL;
      pull_ff <= `LMD_RST_PULL;
      ften_ff <= `LMD_RST_FTEN;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      rd_mem_ff <= 1'b0;
    end else begin
      config_ff <= nxt_config;
      gcl_ff <= nxt_gcl;
      pull_ff <= nxt_pull;
      ften_ff <= nxt_ften;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      rd_mem_ff <= nxt_rd_mem;
    end
  end

  // ==========================================================
  // scan timing and pwm
  logic [15:0] slot_cnt_ff, nxt_slot_cnt;
  logic [3:0] row_ff, nxt_row;
  logic [3:0] col_ff, nxt_col;
  logic [7:0] ramp;
  logic slot_last;
  logic scan_end;
  logic active;
  assign active = config_ff[`LMD_CFG_SSD_BIT] && shutdown_pin_n_i;
  assign slot_last = slot_cnt_ff == SLOT_CYCLES - 16'h0001;
  assign scan_end = slot_last && (row_ff == 4'(ROWS - 1));
  // ramp taken from the slot counter so it moves in step with row and duty
  assign ramp = slot_cnt_ff[7:0]; // 256-step ramp inside each slot
  always_comb begin
    nxt_slot_cnt = slot_cnt_ff + 16'h0001;
    nxt_row = row_ff;
    if (slot_last) begin
      nxt_slot_cnt = 16'h0000;
      nxt_row = next_row(row_ff);
    end
    // duty prefetch walks all columns of the row that comes next
    nxt_col = col_ff + 4'h1;
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt_ff <= 16'h0000;
      row_ff <= 4'h0;
      col_ff <= 4'h0;
    end else begin
      slot_cnt_ff <= nxt_slot_cnt;
      row_ff <= nxt_row;
      col_ff <= nxt_col;
    end
  end
  logic [7:0] fetch_addr;
  assign fetch_addr = 8'(8'(next_row(row_ff)) * 8'(COLS) + 8'(col_ff));
  assign mem_bus.we = mem_we;
  assign mem_bus.waddr = reg_addr_i;
  assign mem_bus.wdata = reg_wdata_i;
  assign mem_bus.raddr = reg_rd_i ? reg_addr_i : fetch_addr;
  lmd_duty_mem #(.AW(8), .DEPTH(ROWS * COLS)) u_mem (
    .clk_i(clk_i),
    .port_if(mem_bus)
  );
  // next row gathered in a shadow set, copied whole when the row changes
  logic [7:0] duty_ff [COLS];
  logic [7:0] shadow_ff [COLS];
  logic [3:0] fetch_col_ff;
  logic fetch_ok_ff;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fetch_col_ff <= 4'h0;
      fetch_ok_ff <= 1'b0;
      for (int i = 0; i < COLS; i++) begin
        duty_ff[i] <= 8'h00;
        shadow_ff[i] <= 8'h00;
      end
    end else begin
      fetch_col_ff <= col_ff;
      fetch_ok_ff <= !reg_rd_i;
      if (fetch_ok_ff) shadow_ff[fetch_col_ff] <= mem_bus.rdata;
      if (slot_last) duty_ff <= shadow_ff;
    end
  end

  // ==========================================================
  // fault detect
  lmd_pkg::lmd_test_state_t tst_ff, nxt_tst;
  lmd_pkg::lmd_kind_t kind_ff, nxt_kind;
  logic [1:0] trig_prev_ff;
  logic [1:0] scans_ff, nxt_scans;
  logic [1:0] trig;
  logic [3:0] sel_row;
  logic [7:0] sample;
  assign trig = ften_ff[`LMD_FTEN_TRIG_HI:`LMD_FTEN_TRIG_LO];
  assign sel_row = row_index(ften_ff[`LMD_FTEN_ROW_HI:`LMD_FTEN_ROW_LO]);
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      sample[b] = (kind_ff == lmd_pkg::LMD_KIND_SHORT)
        ? col_short_sense_i[group_col(ften_ff[`LMD_FTEN_CSEL_BIT], 3'(b))]
        : col_open_sense_i[group_col(ften_ff[`LMD_FTEN_CSEL_BIT], 3'(b))];
    end
  end
  always_comb begin
    nxt_tst = tst_ff;
    nxt_kind = kind_ff;
    nxt_scans = scans_ff;
    nxt_fres = fres_ff;
    case (tst_ff)
      lmd_pkg::LMD_TEST_IDLE: begin
        // only a fresh move away from 00 starts a test; holding does not
        if (trig_prev_ff == `LMD_TRIG_OFF && trig != `LMD_TRIG_OFF) begin
          nxt_tst = lmd_pkg::LMD_TEST_RUN;
          nxt_kind = (trig == `LMD_TRIG_SHORT) ? lmd_pkg::LMD_KIND_SHORT
                                               : lmd_pkg::LMD_KIND_OPEN;
          nxt_scans = 2'h0;
          nxt_fres = 8'h00;
        end
      end
      lmd_pkg::LMD_TEST_RUN: begin
        if (row_ff == sel_row && active && col_ff == 4'h0) begin
          nxt_fres = fres_ff | sample;
        end
        if (scan_end) begin
          nxt_scans = scans_ff + 2'h1;
          if (scans_ff == 2'(`LMD_RESULT_SCANS - 1)) begin
            nxt_tst = lmd_pkg::LMD_TEST_IDLE;
          end
        end
      end
      default: nxt_tst = lmd_pkg::LMD_TEST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tst_ff <= lmd_pkg::LMD_TEST_IDLE;
      kind_ff <= lmd_pkg::LMD_KIND_NONE;
      trig_prev_ff <= `LMD_TRIG_OFF;
      scans_ff <= 2'h0;
      fres_ff <= 8'h00;
    end else begin
      tst_ff <= nxt_tst;
      kind_ff <= nxt_kind;
      trig_prev_ff <= trig;
      scans_ff <= nxt_scans;
      fres_ff <= nxt_fres;
    end
  end

  // ==========================================================
  // matrix drive and de-ghost pulls
  logic [ROWS-1:0] nxt_row_on, row_on_ff, row_pull_ff, nxt_row_pull;
  logic [COLS-1:0] nxt_col_on, col_on_ff, col_pull_ff, nxt_col_pull;
  logic dgen;
  assign dgen = pull_ff[`LMD_PULL_DGEN_BIT];
  always_comb begin
    nxt_row_on = '0;
    nxt_col_on = '0;
    if (active) begin
      nxt_row_on[row_ff] = 1'b1;
      for (int c = 0; c < COLS; c++) begin
        // duty code n lights the first n ramp steps
        nxt_col_on[c] = ramp < duty_ff[c];
      end
    end
    // pulls only on lines that are off
    nxt_row_pull = dgen ? ~nxt_row_on : '0;
    nxt_col_pull = dgen ? ~nxt_col_on : '0;
  end
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      row_on_ff <= '0;
      col_on_ff <= '0;
      row_pull_ff <= '0;
      col_pull_ff <= '0;
    end else begin
      row_on_ff <= nxt_row_on;
      col_on_ff <= nxt_col_on;
      row_pull_ff <= nxt_row_pull;
      col_pull_ff <= nxt_col_pull;
    end
  end

  // ==========================================================
  // outputs
  logic [7:0] rd_out;
  assign rd_out = rd_mem_ff ? mem_bus.rdata : rdata_ff;
  logic [7:0] rd_out_ff;
  logic rvalid_out_ff;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_out_ff <= 8'h00;
      rvalid_out_ff <= 1'b0;
    end else begin
      rd_out_ff <= rd_out;
      rvalid_out_ff <= rvalid_ff;
    end
  end
  assign reg_rdata_o = rd_out_ff;
  assign reg_rvalid_o = rvalid_out_ff;
  assign row_source_on_o = row_on_ff;
  assign column_sink_on_o = col_on_ff;
  assign row_source_pull_en_o = row_pull_ff;
  assign column_sink_pull_en_o = col_pull_ff;
  assign global_current_level_o = gcl_ff;
  assign pull_voltage_select_o = pull_ff;
endmodule

// file: pkg/lmd_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from design files
`ifndef LMD_CFG_SVH
`define LMD_CFG_SVH
`define LMD_OFS_CONFIG 8'hA0
`define LMD_OFS_GCL 8'hA1
`define LMD_OFS_PULL 8'hA4
`define LMD_OFS_FTEN 8'hB0
`define LMD_OFS_FTRES 8'hB1
`define LMD_RST_CONFIG 8'h00
`define LMD_RST_GCL 8'h00
`define LMD_RST_PULL 8'hA2
`define LMD_RST_FTEN 8'h00
`define LMD_CFG_SSD_BIT 0
`define LMD_PULL_DGEN_BIT 3
`define LMD_FTEN_TRIG_HI 6
`define LMD_FTEN_TRIG_LO 5
`define LMD_FTEN_CSEL_BIT 4
`define LMD_FTEN_ROW_HI 3
`define LMD_FTEN_ROW_LO 0
`define LMD_TRIG_OFF 2'h0
`define LMD_TRIG_SHORT 2'h2
`define LMD_NUM_ROWS 9
`define LMD_NUM_COLS 16
`define LMD_DUTY_STEPS 256
`define LMD_SLOT_CYCLES 16'h0100
`define LMD_RESULT_SCANS 2
`endif

// file: pkg/lmd_pkg.sv
// types shared by the led matrix control design
// assumes lmd_cfg.svh supplies the numbers
package lmd_pkg;
  typedef enum {
    LMD_TEST_IDLE,
    LMD_TEST_RUN
  } lmd_test_state_t;
  typedef enum logic [1:0] {
    LMD_KIND_NONE,
    LMD_KIND_OPEN,
    LMD_KIND_SHORT
  } lmd_kind_t;
endpackage

// file: pkg/lmd_mem_if.sv
// write/read port bundle between the control top and the duty memory
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface lmd_mem_if #(
  parameter int AW = 8
);
  logic we;
  logic [AW-1:0] waddr;
  logic [7:0] wdata;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: core/lmd_duty_mem.sv
// per-led duty memory, registered read data
// assumes one clock; contents are never cleared so they survive shutdown
`timescale 1ns/1ps
module lmd_duty_mem #(
  parameter int AW = 8,
  parameter int DEPTH = 144
) (
  input wire logic clk_i,
  lmd_mem_if.mem port_if
);
  logic [7:0] mem_ff [DEPTH];
  logic [7:0] rdata_ff;
  assign port_if.rdata = rdata_ff;
  always_ff @(posedge clk_i) begin
    if (port_if.we && (int'(port_if.waddr) < DEPTH)) begin
      mem_ff[port_if.waddr] <= port_if.wdata;
    end
    rdata_ff <= (int'(port_if.raddr) < DEPTH) ? mem_ff[port_if.raddr] : 8'h00;
  end
endmodule

// file: tb/lmd_ctrl_props.sv
// concurrent checks on the led matrix control top ports
// assumes binding to lmd_ctrl, one clock domain
`timescale 1ns/1ps
module lmd_ctrl_props #(
  parameter int ROWS = 9,
  parameter int COLS = 16
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic shutdown_pin_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rvalid_o,
  input wire logic [ROWS-1:0] row_source_on_o,
  input wire logic [COLS-1:0] column_sink_on_o,
  input wire logic [ROWS-1:0] row_source_pull_en_o,
  input wire logic [COLS-1:0] column_sink_pull_en_o,
  input wire logic [7:0] global_current_level_o,
  input wire logic [7:0] pull_voltage_select_o
);
  // ==========
  // soft shutdown bit as last written
  logic run_ff;
  logic nxt_run;
  logic dark;
  assign dark = row_source_on_o == '0 && column_sink_on_o == '0;
  always_comb begin
    nxt_run = run_ff;
    if (reg_wr_i && reg_addr_i == 8'hA0) begin
      nxt_run = reg_wdata_i[0];
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
    end
  end
  // ==========
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  hw_blank_a: assert property (!shutdown_pin_n_i [*4] |-> dark)
    else $error("matrix lit in hardware shutdown");
  soft_blank_a: assert property (!run_ff [*4] |-> dark)
    else $error("matrix lit in soft shutdown");
  one_row_a: assert property ($onehot0(row_source_on_o))
    else $error("more than one row driven");
  row_pull_a: assert property ((row_source_pull_en_o & row_source_on_o) == '0)
    else $error("row pull while row conducts");
  col_pull_a: assert property ((column_sink_pull_en_o & column_sink_on_o) == '0)
    else $error("column pull while column sinks");
  read_answer_a: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
    else $error("read not answered in two cycles");
  answer_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i, 2))
    else $error("read answer without read");
  gcl_hold_a: assert property ($changed(global_current_level_o) |->
    $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("current level changed without write");
  pvs_hold_a: assert property ($changed(pull_voltage_select_o) |->
    $past(reg_wr_i) || $past(reg_wr_i, 2))
    else $error("pull select changed without write");
  lit_c: cover property (!dark);
  pull_c: cover property (row_source_pull_en_o != '0);
  hw_c: cover property (!shutdown_pin_n_i [*4]);
endmodule
bind lmd_ctrl lmd_ctrl_props #(.ROWS(ROWS), .COLS(COLS)) i_lmd_ctrl_props (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .shutdown_pin_n_i(shutdown_pin_n_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rvalid_o(reg_rvalid_o),
  .row_source_on_o(row_source_on_o), .column_sink_on_o(column_sink_on_o),
  .row_source_pull_en_o(row_source_pull_en_o),
  .column_sink_pull_en_o(column_sink_pull_en_o),
  .global_current_level_o(global_current_level_o),
  .pull_voltage_select_o(pull_voltage_select_o));

// file: tb/lmd_host.sv
// host controller model driving the register port
// assumes outputs change at falling clock edges
`timescale 1ns/1ps
module lmd_host #(
  parameter int SCAN = 288
) (
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // ==========
  // bus cycles
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    @(negedge clk_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_i);
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        break;
      end
    end
  endtask
  // one detect run: setup, clear, set, wait out two scans
  task automatic arm(input logic [7:0] code);
    wr(8'hA1, 8'h0F);
    wr(8'hA4, 8'h00);
    wr(8'hB0, 8'h00);
    wr(8'hB0, code);
    repeat (2 * SCAN + 6) @(negedge clk_i);
  endtask
endmodule

// file: tb/lmd_ctrl_bench.sv
// self-checking bench for the led matrix control top
// assumes host model and checker compiled before
`timescale 1ns/1ps
module lmd_ctrl_bench;
  localparam int SCAN = 9 * 32;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic pin_n = 1'b1;
  logic [15:0] op_s = 16'h0000;
  logic [15:0] sh_s = 16'h0000;
  logic wr, rd, rv;
  logic [7:0] addr, wd, rdat, gcl, pvs;
  logic [8:0] rows, rpull;
  logic [15:0] cols, cpull;
  int fails = 0;
  int check_count = 0;
  always #4 clk_i = ~clk_i;
  lmd_ctrl #(.SLOT_CYCLES(16'h0020)) i_lmd_ctrl (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .shutdown_pin_n_i(pin_n), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv), .col_open_sense_i(op_s),
    .col_short_sense_i(sh_s), .row_source_on_o(rows), .column_sink_on_o(cols),
    .row_source_pull_en_o(rpull), .column_sink_pull_en_o(cpull),
    .global_current_level_o(gcl), .pull_voltage_select_o(pvs));
  lmd_host #(.SCAN(SCAN)) i_lmd_host (.clk_i(clk_i), .rvalid_i(rv), .rdata_i(rdat),
    .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wd));
  // ==========
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_lmd_host.rd(a, v);
    chk(v, exp);
  endtask
  // counts lit cycles, cycles of led 0 on and cycles with row 1 and column 15 pulls both on over a scan
  task automatic scan_cnt(output int lit, output int led, output int pul);
    lit = 0;
    led = 0;
    pul = 0;
    repeat (SCAN) begin
      @(negedge clk_i);
      lit += (rows != 9'h000) ? 1 : 0;
      led += (rows[0] === 1'b1 && cols[0] === 1'b1) ? 1 : 0;
      pul += (rpull[1] === 1'b1 && cpull[15] === 1'b1) ? 1 : 0;
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    rchk(8'hA0, 8'h00);
    rchk(8'hA1, 8'h00);
    rchk(8'hA4, 8'hA2);
    rchk(8'hB0, 8'h00);
    rchk(8'hB1, 8'h00);
    rchk(8'hC0, 8'h00);
  endtask
  task automatic t_regs();
    i_lmd_host.wr(8'hA1, 8'h55);
    rchk(8'hA1, 8'h55);
    chk(gcl, 8'h55);
    i_lmd_host.wr(8'hB1, 8'hFF);
    rchk(8'hB1, 8'h00);
    i_lmd_host.wr(8'hB0, 8'h81);
    rchk(8'hB0, 8'h01);
    i_lmd_host.wr(8'hB0, 8'h00);
  endtask
  task automatic t_run();
    int lit, led, pul;
    // every duty word written so no unknown reaches the drive
    for (int a = 0; a < 144; a++) begin
      i_lmd_host.wr(8'(a), (a == 0) ? 8'h04 : 8'h00);
    end
    i_lmd_host.wr(8'hA4, 8'hAA);
    repeat (SCAN) @(negedge clk_i);
    i_lmd_host.wr(8'hA0, 8'h01);
    repeat (SCAN) @(negedge clk_i);
    scan_cnt(lit, led, pul);
    chk(8'(led), 8'h04);
    chk({7'h00, pul > 0}, 8'h01);
    i_lmd_host.wr(8'hA0, 8'h00);
    repeat (8) @(negedge clk_i);
    scan_cnt(lit, led, pul);
    chk({7'h00, lit > 0}, 8'h00);
    rchk(8'h00, 8'h04);
    i_lmd_host.wr(8'hA0, 8'h01);
    pin_n = 1'b0;
    repeat (8) @(negedge clk_i);
    scan_cnt(lit, led, pul);
    chk({7'h00, lit > 0}, 8'h00);
    i_lmd_host.wr(8'hA1, 8'h0F);
    rchk(8'hA1, 8'h0F);
    pin_n = 1'b1;
    repeat (8) @(negedge clk_i);
    scan_cnt(lit, led, pul);
    chk({7'h00, lit > 0}, 8'h01);
  endtask
  task automatic t_detect(input logic [15:0] o, input logic [15:0] s,
                          input logic [7:0] code, input logic [7:0] exp);
    op_s = o;
    sh_s = s;
    i_lmd_host.arm(code);
    rchk(8'hB1, exp);
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (3) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_regs();
    t_run();
    t_detect(16'h8004, 16'h0000, 8'h21, 8'h81);
    op_s = 16'h0000;
    repeat (2 * SCAN) @(negedge clk_i);
    rchk(8'hB1, 8'h81);
    t_detect(16'h0004, 16'h0000, 8'h61, 8'h01);
    t_detect(16'h0000, 16'h0802, 8'h51, 8'h42);
    t_detect(16'hFFFF, 16'h0000, 8'h20, 8'h00);
    t_detect(16'h8004, 16'h0000, 8'h29, 8'h81);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    final_report();
  end
endmodule
